// File: sim/oam_unit_assertions.sv
// checker: operand addressing unit port assertions
`timescale 1ns/1ps
`default_nettype none
module oam_unit_chk (
  input wire logic        clk, rst, instr_valid, x_mod_en, op_ok, op_illegal,
  input wire logic        src_indexed, no_operands, x_agu_valid, y_agu_valid,
  input wire logic [2:0]  instr_class,
  input wire logic [1:0]  x_prefetch_mode, y_prefetch_mode,
  input wire logic [3:0]  src_mode, offset_register_field, x_prefetch_reg, x_post_amount,
  input wire logic [3:0]  y_prefetch_reg,
  input wire logic [3:0]  shared_offset_reg, x_agu_reg, y_agu_reg,
  input wire logic [15:0] literal_field, x_ptr_value, x_mod_start, x_mod_end,
  input wire logic [15:0] immediate_value, x_ptr_next
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic mac_v;
  assign mac_v = instr_valid && instr_class == 3'h2;
  chk_move_index: assert property (
    instr_valid && instr_class == 3'h0 && src_mode == 4'h6 |=> op_ok && src_indexed)
    else $error("indexed move not accepted");
  chk_shared_offset: assert property (
    instr_valid && instr_class == 3'h0 |=> shared_offset_reg == $past(offset_register_field))
    else $error("offset field not carried");
  chk_one_verdict: assert property (instr_valid |=> op_ok ^ op_illegal)
    else $error("verdict missing or double");
  chk_mac_xreg: assert property (
    mac_v && x_prefetch_mode != 2'h3 && !(x_prefetch_reg inside {4'h8, 4'h9})
    |=> op_illegal && !x_agu_valid) else $error("bad x pointer accepted");
  chk_route_space: assert property (
    (!x_agu_valid || x_agu_reg inside {4'h8, 4'h9}) &&
    (!y_agu_valid || y_agu_reg inside {4'hA, 4'hB}))
    else $error("pointer routed to wrong generator");
  chk_post_amount: assert property (
    mac_v && x_prefetch_mode == 2'h1 && !(x_post_amount inside {4'h2, 4'h4, 4'h6}) |=> op_illegal)
    else $error("bad post amount accepted");
  chk_mac_index: assert property (
    mac_v && x_prefetch_mode == 2'h2 && x_prefetch_reg != 4'h9 |=> op_illegal)
    else $error("indexed on wrong x pointer accepted");
  chk_mac_yindex: assert property (
    mac_v && y_prefetch_mode == 2'h2 && y_prefetch_reg != 4'hB |=> op_illegal)
    else $error("indexed on wrong y pointer accepted");
  chk_disable_lit: assert property (
    instr_valid && instr_class == 3'h4 |=> immediate_value == {2'b00, $past(literal_field[13:0])})
    else $error("disable literal wrong");
  chk_nop_empty: assert property (
    instr_valid && instr_class == 3'h6 |=> no_operands && op_ok) else $error("no-op has operands");
  chk_x_wrap: assert property (
    x_mod_en && x_prefetch_mode == 2'h1 && x_ptr_value + {12'h000, x_post_amount} > x_mod_end
    |=> x_ptr_next == $past(x_mod_start)) else $error("x pointer not wrapped");
  cover property (mac_v ##1 x_agu_valid && y_agu_valid);
  cover property (mac_v ##1 op_illegal);
  cover property (x_mod_en ##1 x_ptr_next == x_mod_start);
endmodule
bind oam_unit oam_unit_chk i_oam_unit_chk (.*);
`default_nettype wire

// File: sim/tb.sv
// testbench: addressing mode unit scenarios
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk, rst, instr_valid, x_mod_en, y_mod_en, op_ok, op_illegal, src_indexed;
  logic        dst_indexed, implied_acc, no_operands, x_agu_valid, y_agu_valid;
  logic [2:0]  instr_class;
  logic [1:0]  x_prefetch_mode, y_prefetch_mode;
  logic [3:0]  src_mode, dst_mode, base_pointer_register, dst_base_register, x_agu_reg;
  logic [3:0]  offset_register_field, x_prefetch_reg, x_post_amount, y_prefetch_reg;
  logic [3:0]  y_post_amount, shared_offset_reg, y_agu_reg;
  logic [15:0] literal_field, x_ptr_value, y_ptr_value, x_mod_start, x_mod_end, y_mod_start;
  logic [15:0] y_mod_end, immediate_value, x_ptr_next, y_ptr_next;
  int          fail_count, num_checks;
  oam_unit i_oam_unit (.*);
  always #2 clk = ~clk;
  task automatic ck1(input logic g, input logic e, input string m);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask
  task automatic ck16(input logic [15:0] g, input logic [15:0] e, input string m);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic go(input logic [2:0] c);
    instr_class = c;
    instr_valid = 1'b1;
    @(negedge clk);
  endtask
  task automatic t_move();
    dst_mode = 4'h6;
    offset_register_field = 4'h5;
    for (int m = 0; m < 10; m++) begin
      src_mode = 4'(m);
      go(3'h0);
      ck1(op_ok, 1'b1, "move mode");
      ck1(src_indexed, m == 6, "src indexed");
      ck1(dst_indexed, 1'b1, "dst indexed");
      ck16(16'(shared_offset_reg), 16'h0005, "offset");
    end
    src_mode = 4'hA;
    go(3'h0);
    ck1(op_illegal, 1'b1, "bad mode");
    src_mode = 4'h0;
    dst_mode = 4'hB;
    go(3'h0);
    ck1(op_illegal, 1'b1, "bad dst mode");
    ck1(implied_acc, 1'b0, "move not implied");
    dst_mode = 4'h6;
    src_mode = 4'h6;
    go(3'h1);
    ck1(src_indexed, 1'b1, "acc indexed");
  endtask
  task automatic mac(input logic [3:0] xr, yr, input logic [1:0] xm, ym,
                     input logic [3:0] amt, input logic ok);
    {x_prefetch_reg, y_prefetch_reg, x_prefetch_mode, y_prefetch_mode} = {xr, yr, xm, ym};
    x_post_amount = amt;
    go(3'h2);
    ck1(op_illegal, !ok, "mac verdict");
    ck1(x_agu_valid, ok && xm != 2'h3, "x agu");
    ck1(y_agu_valid, ok && ym != 2'h3, "y agu");
    ck16({8'h00, y_agu_reg, x_agu_reg}, {8'h00, yr, xr}, "agu regs");
    ck1(implied_acc, 1'b1, "mac implied");
  endtask
  task automatic t_mac();
    mac(4'h9, 4'hA, 2'h2, 2'h1, 4'h4, 1'b1);
    mac(4'h8, 4'hB, 2'h1, 2'h2, 4'h2, 1'b1);
    mac(4'h8, 4'hA, 2'h1, 2'h0, 4'h6, 1'b1);
    mac(4'h8, 4'hA, 2'h1, 2'h0, 4'h3, 1'b0);
    mac(4'h7, 4'hA, 2'h0, 2'h0, 4'h2, 1'b0);
    mac(4'hA, 4'h8, 2'h0, 2'h0, 4'h2, 1'b0);
    mac(4'h8, 4'hA, 2'h2, 2'h0, 4'h2, 1'b0);
    mac(4'h9, 4'hA, 2'h0, 2'h2, 4'h2, 1'b0);
    mac(4'h8, 4'hA, 2'h3, 2'h0, 4'h2, 1'b1);
  endtask
  task automatic t_lit();
    literal_field = 16'h8001;
    go(3'h3);
    ck16(immediate_value, 16'h8001, "branch lit");
    literal_field = 16'hFFFF;
    go(3'h4);
    ck16(immediate_value, 16'h3FFF, "disable lit");
    src_mode = 4'h8;
    literal_field = 16'hABCD;
    go(3'h0);
    ck16(immediate_value, 16'h00CD, "lit8");
    go(3'h5);
    ck1(implied_acc, 1'b1, "implied");
    go(3'h6);
    ck1(no_operands, 1'b1, "nop");
    go(3'h7);
    ck1(no_operands, 1'b0, "other has operands");
    ck1(implied_acc, 1'b0, "other not implied");
  endtask
  task automatic t_mod();
    instr_valid = 1'b0;
    {x_mod_en, y_mod_en, x_prefetch_mode, y_prefetch_mode} = 6'b11_0101;
    {x_mod_start, x_mod_end, x_ptr_value} = {16'h1000, 16'h100F, 16'h100E};
    {y_mod_start, y_mod_end, y_ptr_value} = {16'h2000, 16'h2007, 16'h2004};
    {x_post_amount, y_post_amount} = 8'h26;
    @(negedge clk);
    ck16(x_ptr_next, 16'h1000, "x wrap");
    ck16(y_ptr_next, 16'h2000, "y wrap");
    x_ptr_value = 16'h1000;
    y_mod_en = 1'b0;
    @(negedge clk);
    ck16(x_ptr_next, 16'h1002, "x step");
    ck16(y_ptr_next, 16'h200A, "y off");
  endtask
  initial begin
    {clk, rst, instr_valid, x_mod_en, y_mod_en, instr_class} = 8'b0100_0000;
    {src_mode, dst_mode, base_pointer_register, dst_base_register} = 16'h0000;
    {offset_register_field, x_prefetch_reg, x_post_amount, y_prefetch_reg} = 16'h0000;
    {x_prefetch_mode, y_prefetch_mode, y_post_amount, literal_field} = 24'h0_0000;
    {x_ptr_value, y_ptr_value, x_mod_start, x_mod_end, y_mod_start, y_mod_end} = '0;
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    ck1(op_ok, 1'b0, "reset");
    y_post_amount = 4'h2;
    t_move();
    t_mac();
    t_lit();
    t_mod();
    results();
  end
  initial begin
    #20000;
    fail_count++;
    results();
  end
endmodule
`default_nettype wire

// File: src/oam_mod_if.sv
// interface: one modulo pointer wrap request and result
`timescale 1ns/1ps
`default_nettype none
interface oam_mod_if;
  logic        en;
  logic [15:0] ptr;
  logic [15:0] start;
  logic [15:0] stop;
  logic        up;
  logic [15:0] wrapped;
  modport user (output en, ptr, start, stop, up, input wrapped);
  modport unit (input en, ptr, start, stop, up, output wrapped);
endinterface
`default_nettype wire

// File: src/oam_modulo.sv
// modulo wrap of one data pointer
`timescale 1ns/1ps
`default_nettype none
module oam_modulo (
  oam_mod_if.unit m
);
  always_comb begin
    m.wrapped = m.ptr;
    if (m.en && m.up && (m.ptr > m.stop)) begin // RL9
      m.wrapped = m.start;
    end else if (m.en && !m.up && (m.ptr < m.start)) begin // RL9
      m.wrapped = m.stop;
    end
  end
endmodule
`default_nettype wire

// File: src/oam_pkg.sv
// package: addressing mode encodings and field layouts
package oam_pkg;
  localparam int DATA_W   = 16;
  localparam int REG_W    = 4;
  localparam int BR_LIT_W = 16;
  localparam int DI_LIT_W = 14;
  localparam int LIT8_W   = 8;
  localparam logic [3:0] REG_XA = 4'h8;
  localparam logic [3:0] REG_XB = 4'h9;
  localparam logic [3:0] REG_YA = 4'hA;
  localparam logic [3:0] REG_YB = 4'hB;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [3:0] POST_MOD_2 = 4'h2;
  localparam logic [3:0] POST_MOD_4 = 4'h4;
  localparam logic [3:0] POST_MOD_6 = 4'h6;

  typedef enum logic [3:0] {
    OAM_MODE_DIRECT   = 4'b0000,
    OAM_MODE_IND      = 4'b0001,
    OAM_MODE_POSTINC  = 4'b0010,
    OAM_MODE_POSTDEC  = 4'b0011,
    OAM_MODE_PREINC   = 4'b0100,
    OAM_MODE_PREDEC   = 4'b0101,
    OAM_MODE_INDEXED  = 4'b0110,
    OAM_MODE_LITOFF   = 4'b0111,
    OAM_MODE_LIT8     = 4'b1000,
    OAM_MODE_LIT16    = 4'b1001
  } oam_mode_e;

  typedef enum logic [2:0] {
    OAM_CLS_MOVE   = 3'b000,
    OAM_CLS_ACC    = 3'b001,
    OAM_CLS_MAC    = 3'b010,
    OAM_CLS_BRANCH = 3'b011,
    OAM_CLS_INTERRUPT_DISABLE_OP   = 3'b100,
    OAM_CLS_IMPL   = 3'b101,
    OAM_CLS_NOP    = 3'b110,
    OAM_CLS_OTHER  = 3'b111
  } oam_class_e;

  typedef enum logic [1:0] {
    OAM_MAC_IND   = 2'b00,
    OAM_MAC_POST  = 2'b01,
    OAM_MAC_INDEX = 2'b10,
    OAM_MAC_NONE  = 2'b11
  } oam_macmode_e;
endpackage

// File: src/oam_unit.sv
// operand addressing mode unit: decode, legality, prefetch routing, modulo
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RL1: move and accumulator accept indexed mode
// RL2: move modes independent, one shared offset field
// RL3: full mode set including 8/16-bit literals
// RL4: mac prefetch pointers only registers eight-eleven
// RL5: regs 8,9 to X; 10,11 to Y
// RL6: mac modes: indirect, post 2/4/6, indexed
// RL7: branch 16-bit signed, disable 14-bit unsigned
// RL8: implied operands; no-op carries none
// RL9: hardware modulo wrap of X and Y data pointers
// RL10: one X and one Y circular buffer
// RL11: mac indexed only on regs nine, eleven
// RL12: software keeps addresses in right space
module oam_unit (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // decoded instruction
  input  wire logic        instr_valid,
  input  wire logic [2:0]  instr_class,
  input  wire logic [3:0]  src_mode,
  input  wire logic [3:0]  dst_mode,
  input  wire logic [3:0]  base_pointer_register,
  input  wire logic [3:0]  dst_base_register,
  input  wire logic [3:0]  offset_register_field,
  input  wire logic [15:0] literal_field,
  input  wire logic [3:0]  x_prefetch_reg,
  input  wire logic [1:0]  x_prefetch_mode,
  input  wire logic [3:0]  x_post_amount,
  input  wire logic [3:0]  y_prefetch_reg,
  input  wire logic [1:0]  y_prefetch_mode,
  input  wire logic [3:0]  y_post_amount,
  // register values
  input  wire logic [15:0] x_ptr_value,
  input  wire logic [15:0] y_ptr_value,
  // modulo setup
  input  wire logic        x_mod_en,
  input  wire logic [15:0] x_mod_start,
  input  wire logic [15:0] x_mod_end,
  input  wire logic        y_mod_en,
  input  wire logic [15:0] y_mod_start,
  input  wire logic [15:0] y_mod_end,
  // results
  output logic             op_ok,
  output logic             op_illegal,
  output logic             src_indexed,
  output logic             dst_indexed,
  output logic [3:0]       shared_offset_reg,
  output logic [15:0]      immediate_value,
  output logic             implied_acc,
  output logic             no_operands,
  output logic             x_agu_valid,
  output logic [3:0]       x_agu_reg,
  output logic             y_agu_valid,
  output logic [3:0]       y_agu_reg,
  output logic [15:0]      x_ptr_next,
  output logic [15:0]      y_ptr_next
);
  oam_mod_if xm ();
  oam_mod_if ym ();

  oam_modulo u_xmod (.m(xm));
  oam_modulo u_ymod (.m(ym));

  function automatic logic full_mode_ok(input logic [3:0] md);
    full_mode_ok = (md <= oam_pkg::OAM_MODE_LIT16); // RL3
  endfunction

  function automatic logic mac_ok(input logic [3:0] r, input logic [1:0] md,
                                  input logic [3:0] amt, input logic is_x);
    logic reg_ok;
    logic mode_ok;
    reg_ok = is_x ? (r == oam_pkg::REG_XA || r == oam_pkg::REG_XB)
                  : (r == oam_pkg::REG_YA || r == oam_pkg::REG_YB); // RL4 RL5
    case (md)
      oam_pkg::OAM_MAC_IND:   mode_ok = 1'b1;
      oam_pkg::OAM_MAC_POST:  mode_ok = (amt == oam_pkg::POST_MOD_2 ||
                                         amt == oam_pkg::POST_MOD_4 ||
                                         amt == oam_pkg::POST_MOD_6); // RL6
      oam_pkg::OAM_MAC_INDEX: mode_ok = is_x ? (r == oam_pkg::REG_XB)
                                             : (r == oam_pkg::REG_YB); // RL11
      default:                mode_ok = 1'b1;
    endcase
    mac_ok = (md == oam_pkg::OAM_MAC_NONE) || (reg_ok && mode_ok);
  endfunction

  function automatic logic [15:0] post_ptr(input logic [15:0] p, input logic [1:0] md,
                                          input logic [3:0] amt);
    post_ptr = (md == oam_pkg::OAM_MAC_POST) ? p + {12'h000, amt} : p;
  endfunction

  logic ok_c;
  logic is_mv;
  logic is_mac;
  logic [15:0] imm_c;

  assign is_mv  = (instr_class == oam_pkg::OAM_CLS_MOVE) ||
                  (instr_class == oam_pkg::OAM_CLS_ACC);
  assign is_mac = (instr_class == oam_pkg::OAM_CLS_MAC);

  always_comb begin
    case (instr_class)
      oam_pkg::OAM_CLS_MOVE:   ok_c = full_mode_ok(src_mode) && full_mode_ok(dst_mode); // RL2
      oam_pkg::OAM_CLS_ACC:    ok_c = full_mode_ok(src_mode); // RL1
      oam_pkg::OAM_CLS_MAC:    ok_c = mac_ok(x_prefetch_reg, x_prefetch_mode, x_post_amount,
                                             1'b1) &&
                                      mac_ok(y_prefetch_reg, y_prefetch_mode, y_post_amount,
                                             1'b0); // RL4 RL6
      default:                 ok_c = 1'b1;
    endcase
  end

  always_comb begin
    case (instr_class)
      oam_pkg::OAM_CLS_BRANCH: imm_c = literal_field; // RL7
      oam_pkg::OAM_CLS_INTERRUPT_DISABLE_OP:   imm_c = {2'b00, literal_field[13:0]}; // RL7
      default: begin
        if (src_mode == oam_pkg::OAM_MODE_LIT8) begin
          imm_c = {8'h00, literal_field[7:0]}; // RL3
        end else begin
          imm_c = literal_field; // RL3
        end
      end
    endcase
  end

  assign xm.en    = x_mod_en; // RL10
  assign xm.ptr   = post_ptr(x_ptr_value, x_prefetch_mode, x_post_amount);
  assign xm.start = x_mod_start;
  assign xm.stop  = x_mod_end;
  assign xm.up    = 1'b1;
  assign ym.en    = y_mod_en; // RL10
  assign ym.ptr   = post_ptr(y_ptr_value, y_prefetch_mode, y_post_amount);
  assign ym.start = y_mod_start;
  assign ym.stop  = y_mod_end;
  assign ym.up    = 1'b1;

  // legality and mode flags
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      op_ok       <= 1'b0;
      op_illegal  <= 1'b0;
      src_indexed <= 1'b0;
      dst_indexed <= 1'b0;
    end else begin
      op_ok       <= instr_valid && ok_c;
      op_illegal  <= instr_valid && !ok_c;
      src_indexed <= instr_valid && is_mv && (src_mode == oam_pkg::OAM_MODE_INDEXED); // RL1
      dst_indexed <= instr_valid && (instr_class == oam_pkg::OAM_CLS_MOVE) &&
                     (dst_mode == oam_pkg::OAM_MODE_INDEXED); // RL2
    end
  end

  // operand fields
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shared_offset_reg <= 4'h0;
      immediate_value   <= oam_pkg::RESET_WORD;
      implied_acc       <= 1'b0;
      no_operands       <= 1'b0;
    end else if (instr_valid) begin
      shared_offset_reg <= offset_register_field; // RL2
      immediate_value   <= imm_c;
      implied_acc       <= (instr_class == oam_pkg::OAM_CLS_IMPL) || is_mac; // RL8
      no_operands       <= (instr_class == oam_pkg::OAM_CLS_NOP); // RL8
    end
  end

  // prefetch routing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      x_agu_valid <= 1'b0;
      x_agu_reg   <= 4'h0;
      y_agu_valid <= 1'b0;
      y_agu_reg   <= 4'h0;
      x_ptr_next  <= oam_pkg::RESET_WORD;
      y_ptr_next  <= oam_pkg::RESET_WORD;
    end else begin
      x_agu_valid <= instr_valid && is_mac && ok_c &&
                     (x_prefetch_mode != oam_pkg::OAM_MAC_NONE); // RL5
      y_agu_valid <= instr_valid && is_mac && ok_c &&
                     (y_prefetch_mode != oam_pkg::OAM_MAC_NONE); // RL5
      x_agu_reg   <= x_prefetch_reg;
      y_agu_reg   <= y_prefetch_reg;
      x_ptr_next  <= xm.wrapped; // RL9
      y_ptr_next  <= ym.wrapped; // RL9
    end
  end

  logic unused_ok;
  assign unused_ok = ^{base_pointer_register, dst_base_register};
endmodule
`default_nettype wire
